// File: rtl/apm_fifo2.sv
// Purpose: small result buffer with valid/ready on both sides
// Assumes: DEPTH a power of two
// Notes:   read data comes straight from the storage flops
`timescale 1ns/1ps
module apm_fifo2
  import apm_pkg::*;
#(
  parameter int unsigned W     = RES_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic   clock,
  input  wire logic   reset,
  apm_stream_if.snk   wr,
  apm_stream_if.src   rd
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } apm_fifo_state_type;

  apm_fifo_state_type q, d;
  logic               do_wr;
  logic               do_rd;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("fifo depth must be a power of two, at least 2");
  end

  assign wr.ready = (q.cnt != (AW+1)'(DEPTH));
  assign rd.valid = (q.cnt != '0);
  assign rd.data  = q.mem[q.rp];
  assign do_wr    = wr.valid && wr.ready;
  assign do_rd    = rd.valid && rd.ready;

  always_comb begin
    d = q;
    if (do_wr) begin
      d.mem[q.wp] = wr.data;
      d.wp        = q.wp + AW'(1);
    end
    if (do_rd) begin
      d.rp = q.rp + AW'(1);
    end
    if (do_wr && !do_rd) begin
      d.cnt = q.cnt + (AW+1)'(1);
    end else if (do_rd && !do_wr) begin
      d.cnt = q.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : apm_fifo2

// File: rtl/apm_host.sv
// Purpose: host that drives the frame and serial clock of a serial converter
// Assumes: device powered from the same supply event as this block's reset
// Notes:   frame and serial clock idle high; results leave through a buffer
`timescale 1ns/1ps
module apm_host
  import apm_pkg::*;
#(
  parameter int unsigned SCLK_HALF = SCLK_HALF_DEF
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic [1:0]        cmd_op,
  output logic                   res_valid,
  input  wire logic              res_ready,
  output logic [DATA_W-1:0]      res_data,
  output logic                   res_fmt_err,
  output logic                   dev_powered,
  output logic                   busy,
  output logic                   frame_n,
  output logic                   sclk,
  input  wire logic              result_in
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    apm_state_type         state;
    apm_op_type            op;
    logic                  boot;
    logic                  pend_conv;
    logic                  powered;
    logic                  frame_n;
    logic                  sclk;
    logic [4:0]            falls;
    logic [3:0]            gap;
    logic [FRAME_BITS-1:0] shreg;
    logic                  sync1;
    logic                  sync2;
    logic                  push;
  } apm_host_state_type;

  localparam apm_host_state_type RESET_STATE = '{
    state: ST_IDLE, op: OP_WAKE, boot: 1'b1, pend_conv: 1'b0, powered: 1'b0,
    frame_n: 1'b1, sclk: 1'b1, falls: 5'h00, gap: 4'h0, shreg: '0,
    sync1: 1'b0, sync2: 1'b0, push: 1'b0};

  apm_host_state_type q, d;
  logic               tick;
  logic [4:0]         target;
  logic               start;
  apm_op_type         start_op;

  // slower serial clocks only add margin to the sampling point
  initial begin
    if (SCLK_HALF < HALF_MIN) $error("serial clock above 10 MHz");
    if (SCLK_HALF < 3) $error("half period too short for the input synchroniser");
    if (2 * SCLK_HALF * 10 < PWRUP_CYC) $error("ten clock falls must span the power-up time");
  end

  apm_stream_if #(.W(RES_W)) push_if ();
  apm_stream_if #(.W(RES_W)) pop_if ();

  apm_tick_div #(.HALF(SCLK_HALF)) u_div (
    .clock  (clock),
    .reset  (reset),
    .enable (q.state == ST_FRAME),
    .tick   (tick)
  );

  apm_fifo2 #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock (clock),
    .reset (reset),
    .wr    (push_if),
    .rd    (pop_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer

  // number of clock falls after which the frame is raised
  always_comb begin
    case (q.op)
      OP_CONVERT: target = FALLS_FULL;
      OP_SLEEP:   target = FALLS_SLEEP;
      default:    target = FALLS_AWAKE;
    endcase
  end

  // a convert request while asleep is turned into a dummy wake first
  assign cmd_ready = (q.state == ST_IDLE) && !q.boot && !q.pend_conv && push_if.ready;

  always_comb begin
    start    = 1'b0;
    start_op = OP_WAKE;
    if (q.state == ST_IDLE) begin
      if (q.boot) begin
        start    = 1'b1;
        start_op = OP_WAKE;
      end else if (q.pend_conv) begin
        start    = 1'b1;
        start_op = OP_CONVERT;
      end else if (cmd_valid && cmd_ready) begin
        start = 1'b1;
        if (cmd_op == OP_CONVERT && !q.powered) begin
          start_op = OP_WAKE;
        end else if (cmd_op == OP_CONVERT || cmd_op == OP_SLEEP) begin
          start_op = cmd_op;
        end else begin
          start_op = OP_WAKE;
        end
      end
    end
  end

  always_comb begin
    d       = q;
    d.push  = 1'b0;
    d.sync1 = result_in;
    d.sync2 = q.sync1;
    case (q.state)
      ST_IDLE: begin
        if (start) begin
          d.state     = ST_FRAME;
          d.op        = start_op;
          d.boot      = 1'b0;
          d.pend_conv = (q.pend_conv || q.boot) ? 1'b0
                        : (cmd_op == OP_CONVERT && start_op == OP_WAKE);
          d.frame_n   = 1'b0;
          d.sclk      = 1'b1;
          d.falls     = '0;
        end
      end
      ST_FRAME: begin
        if (tick) begin
          if (q.sclk) begin
            // sample just before the fall moves the device to the next bit
            d.sclk  = 1'b0;
            d.falls = q.falls + 5'h01;
            d.shreg = {q.shreg[FRAME_BITS-2:0], q.sync2};
          end else begin
            d.sclk = 1'b1;
            if (q.falls == target) begin
              d.frame_n = 1'b1;
              d.state   = ST_GAP;
              d.gap     = '0;
              case (q.op)
                OP_CONVERT: begin
                  d.push    = 1'b1;
                  d.powered = 1'b1;
                end
                OP_SLEEP: d.powered = 1'b0;
                default:  d.powered = 1'b1;
              endcase
            end
          end
        end
      end
      ST_GAP: begin
        // release delay plus quiet time before the next frame fall
        d.gap = q.gap + 4'h1;
        if (q.gap == GAP_LAST) begin
          d.state = ST_IDLE;
        end
      end
      default: d.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign push_if.valid = q.push;
  assign push_if.data  = {(q.shreg[FRAME_BITS-1 -: LEAD_W] != '0), q.shreg[DATA_W-1:0]};
  assign pop_if.ready  = res_ready;
  assign res_valid     = pop_if.valid;
  assign res_data      = pop_if.data[DATA_W-1:0];
  assign res_fmt_err   = pop_if.data[DATA_W];
  assign dev_powered   = q.powered;
  assign busy          = (q.state != ST_IDLE) || q.boot || q.pend_conv;
  assign frame_n       = q.frame_n;
  assign sclk          = q.sclk;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_STAY_POWERED: assert property (@(posedge clock) disable iff (reset)
    ($rose(q.frame_n) && $past(q.op) != OP_SLEEP) |-> $past(q.falls) >= FALLS_AWAKE)
    else $error("frame raised before ten clock falls on a powered frame");

  AST_SIXTEEN: assert property (@(posedge clock) disable iff (reset)
    ($rose(q.frame_n) && $past(q.op) == OP_CONVERT) |-> $past(q.falls) == FALLS_FULL && q.push)
    else $error("conversion frame not sixteen clocks or result not pushed");

  AST_SLEEP_WINDOW: assert property (@(posedge clock) disable iff (reset)
    ($rose(q.frame_n) && $past(q.op) == OP_SLEEP)
      |-> $past(q.falls) >= FALLS_GLITCH && $past(q.falls) < FALLS_AWAKE && !q.powered)
    else $error("sleep frame raised outside the power-down window");

  AST_QUIET: assert property (@(posedge clock) disable iff (reset)
    $rose(q.frame_n) |-> q.frame_n [*6])
    else $error("frame fell again before release and quiet time");

  AST_CONV_AWAKE: assert property (@(posedge clock) disable iff (reset)
    ($fell(q.frame_n) && q.op == OP_CONVERT) |-> $past(q.powered))
    else $error("conversion started while device believed asleep");

  AST_BOOT_DUMMY: assert property (@(posedge clock) disable iff (reset)
    ($fell(q.frame_n) && $past(q.boot)) |-> q.op == OP_WAKE)
    else $error("first frame after reset is not a dummy wake");

  AST_WAKE_POWER: assert property (@(posedge clock) disable iff (reset)
    ($rose(q.frame_n) && $past(q.op) == OP_WAKE) |-> q.powered && $past(q.falls) == FALLS_AWAKE)
    else $error("wake frame did not reach ten falls or mark device powered");

  AST_SCLK_IDLE: assert property (@(posedge clock) disable iff (reset)
    q.frame_n |-> q.sclk)
    else $error("serial clock low while frame is high");

  AST_NO_LOSS: assert property (@(posedge clock) disable iff (reset)
    push_if.valid |-> push_if.ready)
    else $error("result pushed into a full buffer");

  // frame shape: each frame opens from rest and counts at most sixteen falls
  AST_FRAME_START: assert property (@(posedge clock) disable iff (reset)
    $fell(q.frame_n) |-> q.sclk && q.falls == 5'h00)
    else $error("frame opened with serial clock low or stale fall count");

  AST_FALLS_MAX: assert property (@(posedge clock) disable iff (reset)
    q.falls <= FALLS_FULL)
    else $error("more than sixteen clock falls in one frame");

  AST_ONLY_CONV_PUSH: assert property (@(posedge clock) disable iff (reset)
    q.push |-> q.op == OP_CONVERT && $rose(q.frame_n))
    else $error("result pushed outside the end of a conversion frame");

  AST_PEND_CONV: assert property (@(posedge clock) disable iff (reset)
    ($fell(q.frame_n) && $past(q.pend_conv)) |-> q.op == OP_CONVERT)
    else $error("frame after a dummy wake is not the held conversion");

  // belief may only move where the device itself decides, at a frame rise
  AST_POWER_AT_RISE: assert property (@(posedge clock) disable iff (reset)
    $changed(q.powered) |-> $rose(q.frame_n))
    else $error("power belief changed away from a frame rise");

  // link lines rest during release and quiet time
  AST_GAP_REST: assert property (@(posedge clock) disable iff (reset)
    (q.state == ST_GAP) |-> q.sclk && q.frame_n)
    else $error("frame or serial clock moved during the gap");

  COV_CONVERT: cover property (@(posedge clock) disable iff (reset)
    $rose(q.frame_n) && $past(q.op) == OP_CONVERT);
  COV_SLEEP: cover property (@(posedge clock) disable iff (reset)
    $rose(q.frame_n) && $past(q.op) == OP_SLEEP);
  COV_WAKE_THEN_CONV: cover property (@(posedge clock) disable iff (reset)
    q.pend_conv && $fell(q.frame_n));
  COV_STALL: cover property (@(posedge clock) disable iff (reset)
    res_valid && !res_ready && !push_if.ready);
  COV_BOOT_WAKE: cover property (@(posedge clock) disable iff (reset)
    $fell(q.frame_n) && $past(q.boot));

endmodule : apm_host

// File: rtl/apm_pkg.sv
// Purpose: shared constants and types of the converter power-mode host
// Assumes: 50 MHz system clock
// Notes:   times are kept as printed, cycle counts derived from them
package apm_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_QUIET_NS    = 60;
  localparam int unsigned T_RELEASE_NS  = 35;
  localparam int unsigned T_PWRUP_NS    = 1000;
  localparam int unsigned T_SCLK_MIN_NS = 100;

  // least times round up to whole cycles
  localparam int unsigned QUIET_CYC   = (T_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RELEASE_CYC = (T_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWRUP_CYC   = (T_PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HALF_MIN    = (T_SCLK_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYC     = RELEASE_CYC + QUIET_CYC;

  localparam int unsigned SCLK_HALF_DEF = 4;
  localparam int unsigned FIFO_DEPTH    = 2;

  localparam logic [4:0] FALLS_FULL  = 5'h10;
  localparam logic [4:0] FALLS_AWAKE = 5'h0a;
  localparam logic [4:0] FALLS_SLEEP = 5'h04;
  localparam logic [4:0] FALLS_GLITCH = 5'h02;
  localparam logic [3:0] GAP_LAST    = 4'(GAP_CYC - 1);

  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned DATA_W     = 12;
  localparam int unsigned LEAD_W     = 4;
  localparam int unsigned RES_W      = DATA_W + 1;

  typedef logic [1:0] apm_op_type;
  localparam apm_op_type OP_CONVERT = 2'h0;
  localparam apm_op_type OP_SLEEP   = 2'h1;
  localparam apm_op_type OP_WAKE    = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_GAP} apm_state_type;

endpackage : apm_pkg

// File: rtl/apm_stream_if.sv
// Purpose: valid/ready word stream between host modules
// Assumes: one clock domain
// Notes:   word taken when valid and ready are both high
`timescale 1ns/1ps
interface apm_stream_if #(parameter int unsigned W = 13);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : apm_stream_if

// File: rtl/apm_tick_div.sv
// Purpose: serial clock half-period enable divider
// Assumes: enable held high while a frame runs
// Notes:   restarts from zero whenever enable drops
`timescale 1ns/1ps
module apm_tick_div
  import apm_pkg::*;
#(
  parameter int unsigned HALF = SCLK_HALF_DEF
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic enable,
  output logic      tick
);
  localparam int unsigned CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } apm_div_state_type;

  apm_div_state_type q, d;

  initial begin
    if (HALF < 1) $error("divider half period must be at least one cycle");
  end

  always_comb begin
    d = q;
    if (!enable || q.cnt == LAST) begin
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  assign tick = enable && (q.cnt == LAST);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : apm_tick_div

// File: tb/apm_adc_model.sv
// Purpose: behavioural serial converter on the far side of the host
// Assumes: frame and serial clock come only from the host
// Notes:   the data pin has no pull; a released pin shows the inverse of its last level
`timescale 1ns/1ps
module apm_adc_model
  import apm_pkg::*;
(
  input  wire logic              frame_n,
  input  wire logic              sclk,
  input  wire logic [DATA_W-1:0] sample,
  input  wire logic              lead_bad,
  output logic                   result_out,
  output logic                   powered,
  output logic [4:0]             falls,
  output logic                   track
);
  logic [15:0] shreg;
  logic        drive;
  logic        last;
  logic        waking;

  // power-on state is open; start asleep so the boot wake has to work
  initial begin
    powered    = 1'b0;
    drive      = 1'b0;
    falls      = 5'h00;
    last       = 1'b0;
    shreg      = 16'h0000;
    result_out = 1'b1;
    track      = 1'b0;
    waking     = 1'b0;
  end

  task automatic show;
    if (drive) begin
      result_out = shreg[4'hf - falls[3:0]];
      last       = result_out;
    end else begin
      result_out = ~last;
    end
  endtask : show

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge frame_n) begin
    falls = 5'h00;
    drive = 1'b1;
    waking = !powered;
    track  = 1'b0;
    // a frame started while asleep yields junk, so an unwoken convert shows up
    shreg = {lead_bad ? 4'h5 : 4'h0, powered ? sample : ~sample};
    show();
  end

  always @(negedge sclk) begin
    if (!frame_n && drive) begin
      falls = falls + 5'h01;
      if (falls == FALLS_FULL) drive = 1'b0;
      show();
    end
  end

  // only a frame started while asleep goes back to track, on its first clock edge
  always @(sclk) begin
    if (!frame_n && waking) track = 1'b1;
  end

  always @(posedge frame_n) begin
    if (powered && falls >= FALLS_GLITCH && falls < FALLS_AWAKE) begin
      powered = 1'b0;
      track   = 1'b0;
    end
    else if (!powered && falls >= FALLS_AWAKE) powered = 1'b1;
    // released at once, well inside the release delay
    drive = 1'b0;
    show();
  end
endmodule : apm_adc_model

// File: tb/tb_apm_host.sv
// Purpose: self-checking bench of the converter power-mode host
// Assumes: converter model starts powered down
// Notes:   checks go through one task; monitors watch frame spacing and clock rate
`timescale 1ns/1ps
module tb_apm_host;
  import apm_pkg::*;
  localparam int unsigned HALF = 4;

  logic              clock;
  logic              reset;
  logic              cmd_valid;
  logic              cmd_ready;
  logic [1:0]        cmd_op;
  logic              res_valid;
  logic              res_ready;
  logic [DATA_W-1:0] res_data;
  logic              res_fmt_err;
  logic              dev_powered;
  logic              busy;
  logic              frame_n;
  logic              sclk;
  logic              result_in;
  logic [DATA_W-1:0] sample;
  logic              lead_bad;
  logic              adc_on;
  logic [4:0]        adc_falls;
  logic              adc_track;
  int                num_errors   = 0;
  int                total_checks = 0;
  int                hi_cnt       = 0;
  int                sc_cnt       = 0;
  logic              seen_fall    = 1'b0;
  logic              prev_frame_n = 1'b1;
  logic              prev_sclk    = 1'b1;

  always #10 clock = ~clock;

  apm_host #(.SCLK_HALF(HALF)) uut (.clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data), .res_fmt_err(res_fmt_err),
    .dev_powered(dev_powered), .busy(busy), .frame_n(frame_n), .sclk(sclk), .result_in(result_in));

  apm_adc_model dev (.frame_n(frame_n), .sclk(sclk), .sample(sample), .lead_bad(lead_bad),
    .result_out(result_in), .powered(adc_on), .falls(adc_falls), .track(adc_track));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // sel 0 waits for cmd_ready, 1 for not busy, 2 for res_valid
  task automatic wait_on(input int sel);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n > 3000) begin
        check(1'b0, 1'b1, "wait timed out");
        finish_test();
      end
    end while (!(sel == 0 ? cmd_ready === 1'b1 : sel == 1 ? busy === 1'b0 : res_valid === 1'b1));
  endtask : wait_on

  task automatic send(input apm_op_type op);
    @(posedge clock);
    cmd_op    <= op;
    cmd_valid <= 1'b1;
    wait_on(0);
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
    wait_on(1);
  endtask : send

  task automatic take(input logic [DATA_W-1:0] d, input logic e);
    wait_on(2);
    check(res_data, d, "result data");
    check(res_fmt_err, e, "lead flag");
    @(posedge clock);
    res_ready <= 1'b1;
    @(posedge clock);
    res_ready <= 1'b0;
  endtask : take

  task automatic load(input logic [DATA_W-1:0] s, input logic bad);
    @(posedge clock);
    sample   <= s;
    lead_bad <= bad;
    send(OP_CONVERT);
    check(adc_falls, FALLS_FULL, "frame length");
    check(adc_on, 1'b1, "converter powered");
  endtask : load

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_boot;
    @(negedge clock);
    check(busy, 1'b1, "busy during boot wake");
    wait_on(0);
    check(adc_falls, FALLS_AWAKE, "boot frame length");
    check(adc_track, 1'b1, "track after wake");
    check(adc_on, 1'b1, "boot wake");
    check(dev_powered, 1'b1, "host belief after boot");
  endtask : t_boot

  task automatic t_convert(input logic [DATA_W-1:0] s, input logic bad);
    load(s, bad);
    take(s, bad);
  endtask : t_convert

  task automatic t_sleep;
    send(OP_SLEEP);
    check(adc_falls, FALLS_SLEEP, "sleep frame length");
    check(adc_on, 1'b0, "converter asleep");
    check(adc_track, 1'b0, "hold while asleep");
    check(dev_powered, 1'b0, "host belief asleep");
    check(res_valid, 1'b0, "no word from sleep");
  endtask : t_sleep

  task automatic t_wake(input apm_op_type op);
    send(op);
    check(adc_falls, FALLS_AWAKE, "wake frame length");
    check(adc_on, 1'b1, "awake");
    check(res_valid, 1'b0, "no word from wake");
  endtask : t_wake

  task automatic t_buffer;
    load(12'h123, 1'b0);
    load(12'hfed, 1'b0);
    repeat (20) @(negedge clock);
    check(cmd_ready, 1'b0, "full buffer refuses");
    take(12'h123, 1'b0);
    take(12'hfed, 1'b0);
    @(negedge clock);
    check(res_valid, 1'b0, "buffer empty");
  endtask : t_buffer

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clock) begin
    if (frame_n === 1'b1) hi_cnt++;
    else begin
      if (prev_frame_n === 1'b1 && seen_fall) check(hi_cnt >= GAP_CYC + 1, 1'b1, "frame gap short");
      if (prev_frame_n === 1'b1) seen_fall = 1'b1;
      hi_cnt = 0;
    end
    if (sclk !== prev_sclk) begin
      check(sc_cnt >= HALF_MIN, 1'b1, "serial clock fast");
      sc_cnt = 0;
    end
    sc_cnt++;
    prev_frame_n = frame_n;
    prev_sclk    = sclk;
  end

  initial begin
    clock     = 1'b0;
    reset     = 1'b1;
    cmd_valid = 1'b0;
    cmd_op    = OP_CONVERT;
    res_ready = 1'b0;
    sample    = 12'h000;
    lead_bad  = 1'b0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    t_boot();
    t_convert(12'h7ff, 1'b0);
    t_convert(12'h800, 1'b0);
    t_convert(12'ha5c, 1'b1);
    t_sleep();
    // one command while asleep: wake frame, gap, then the convert
    t_convert(12'h3c1, 1'b0);
    t_wake(OP_WAKE);
    t_wake(2'h3);
    t_buffer();
    finish_test();
  end
endmodule : tb_apm_host
